// [shared/ahst_defs.vh]
`ifndef AHST_DEFS_VH
`define AHST_DEFS_VH
// register byte offsets
`define AHST_OFF_CAUSE 12'h000
`define AHST_OFF_SWTRG 12'h004
`define AHST_OFF_ENAB 12'h008
`define AHST_OFF_STAT 12'h00C
// cause field positions
`define AHST_CH14_LSB 8
`define AHST_CH14_MSB 11
`define AHST_CH15_LSB 12
`define AHST_CH15_MSB 15
// reset values
`define AHST_RST_CAUSE 16'h0000
`define AHST_RST_SWTRG 8'hFC
`define AHST_RST_ENAB 8'h00
`define AHST_SWTRG_FILL 6'h3F
// software trigger bits
`define AHST_SW0_BIT 0
`define AHST_SW1_BIT 1
// cause codes
`define AHST_C_SW0 4'hE
`define AHST_C_SW1 4'hF
// enable bit of channels 14 and 15
`define AHST_EN_CH14 6
`define AHST_EN_CH15 7
`endif

// [core/ahst_cause_mux.v]
`timescale 1ns/100ps
`include "ahst_defs.vh"
// selects one trigger event for one channel from its 4-bit cause code
module ahst_cause_mux (
    input wire [3:0] cause,
    input wire [3:0] pwm_uf_or_match,
    input wire [3:0] pwm_match,
    input wire capture_unit_zero_evt,
    input wire capture_unit_one_evt,
    input wire gtm_ovf,
    input wire capture_unit_fifteen_evt,
    input wire free_timer_sixteen_evt,
    input wire free_timer_seventeen_evt,
    input wire sw0_evt,
    input wire sw1_evt,
    output reg hit
);
    always @* begin
        case (cause)
            4'h0: hit = pwm_uf_or_match[0]; // [RULE_03]
            4'h1: hit = pwm_uf_or_match[1]; // [RULE_03]
            4'h2: hit = pwm_uf_or_match[2]; // [RULE_03]
            4'h3: hit = pwm_uf_or_match[3]; // [RULE_03]
            4'h4: hit = pwm_match[0]; // [RULE_03]
            4'h5: hit = pwm_match[1]; // [RULE_03]
            4'h6: hit = pwm_match[2]; // [RULE_03]
            4'h7: hit = pwm_match[3]; // [RULE_03]
            4'h8: hit = capture_unit_zero_evt; // [RULE_04]
            4'h9: hit = capture_unit_one_evt; // [RULE_04]
            4'hA: hit = gtm_ovf; // [RULE_04]
            4'hB: hit = capture_unit_fifteen_evt; // [RULE_04]
            4'hC: hit = free_timer_sixteen_evt; // [RULE_05]
            4'hD: hit = free_timer_seventeen_evt; // [RULE_05]
            `AHST_C_SW0: hit = sw0_evt; // [RULE_06]
            `AHST_C_SW1: hit = sw1_evt; // [RULE_06]
            default: hit = 1'b0;
        endcase
    end
endmodule

// [core/ahst_trigger.v]
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ahst_defs.vh"
// How it works
// RULE_01 - cause bits 11:8 pick channel 14 event
// RULE_02 - cause bits 15:12 pick channel 15 event
// RULE_03 - codes 0-7 select pwm pair events
// RULE_04 - codes 8-11 capture and timer overflow
// RULE_05 - codes 12,13 select free timers
// RULE_06 - codes 14,15 select software triggers
// RULE_07 - two software trigger bits start conversion
// RULE_08 - trigger bits never cleared by hardware
// RULE_09 - only rising edge of bit triggers
// RULE_10 - trigger during conversion waits pending
// RULE_11 - both bits: trigger 1 then 0
// RULE_12 - software trigger register resets to FC
// RULE_13 - any of four reset sources resets
// RULE_14 - eight enable bits, bits 0-3 channels 0-3
// RULE_15 - enable one permits, zero blocks conversion
// RULE_16 - enable register resets to zero
// RULE_17 - enable bits 4-7 channels 12-15
// RULE_18 - cause register written as whole word
// RULE_19 - start one clock after strobe-synced flag
// RULE_20 - disabled channel never starts conversion
module ahst_trigger (
    input wire clk_sys,
    input wire sys_rst,
    input wire ext_reset_pin_n,
    input wire break_instruction,
    input wire watchdog_overflow,
    input wire opcode_trap,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire machine_cycle_strobe,
    input wire [3:0] pwm_uf_or_match,
    input wire [3:0] pwm_match,
    input wire capture_unit_zero_evt,
    input wire capture_unit_one_evt,
    input wire gtm_ovf,
    input wire capture_unit_fifteen_evt,
    input wire free_timer_sixteen_evt,
    input wire free_timer_seventeen_evt,
    input wire conv_busy,
    output reg [7:0] chan_enable,
    output reg interrupt_request_flag,
    output reg start_ch14,
    output reg start_ch15
);
    reg [1:0] pin_sync_q;
    reg [15:0] cause_q;
    reg [1:0] sw_q;
    reg [7:0] enab_q;
    reg [1:0] sw_prev_q;
    reg [1:0] sw_pend_q;
    reg [1:0] ev_lat_q;
    reg [1:0] busy_q;
    wire any_rst;
    wire setup;
    wire wr_acc;
    wire [1:0] sw_rise;
    wire [1:0] sw_fire;
    wire hit14;
    wire hit15;
    wire [1:0] fire;
    reg [31:0] rdata_d;
    reg rsel_ok;
    reg [2:0] sv_state_q;
    reg [2:0] sv_state_d;
    reg [1:0] sw_pend_d;
    reg [1:0] ev_lat_d;
    reg [1:0] busy_d;
    reg flag_d;
    wire sv_idle;
    wire any_start;

    // software service: idle, waiting for the start, converting
    localparam [2:0] SV_IDLE = 3'b001;
    localparam [2:0] SV_LAUNCH = 3'b010;
    localparam [2:0] SV_CONV = 3'b100;
    localparam [7:0] SWTRG_RST = `AHST_RST_SWTRG;

    // pin reset is outside the clock domain
    always @(posedge clk_sys) begin
        pin_sync_q <= {pin_sync_q[0], ~ext_reset_pin_n};
    end

    assign any_rst = sys_rst | pin_sync_q[1] | break_instruction
        | watchdog_overflow | opcode_trap; // [RULE_13]

    // zero wait state slave: ready in the access cycle
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & pready;

    always @(posedge clk_sys) begin
        if (any_rst) begin
            cause_q <= `AHST_RST_CAUSE;
            sw_q <= SWTRG_RST[`AHST_SW1_BIT:`AHST_SW0_BIT]; // [RULE_12]
            enab_q <= `AHST_RST_ENAB; // [RULE_16]
        end else if (wr_acc) begin
            case (paddr)
                `AHST_OFF_CAUSE: begin
                    // whole word only, partial strobes ignored
                    if (pstrb[1:0] == 2'h3) begin
                        cause_q <= pwdata[15:0]; // [RULE_18]
                    end
                end
                `AHST_OFF_SWTRG: begin
                    if (pstrb[0]) begin
                        sw_q <= pwdata[1:0]; // [RULE_07] [RULE_08]
                    end
                end
                `AHST_OFF_ENAB: begin
                    if (pstrb[0]) begin
                        enab_q <= pwdata[7:0]; // [RULE_14] [RULE_17]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        rsel_ok = 1'b1;
        case (paddr)
            `AHST_OFF_CAUSE: rdata_d = {16'h0000, cause_q};
            `AHST_OFF_SWTRG: rdata_d = {24'h000000, `AHST_SWTRG_FILL, sw_q}; // [RULE_12]
            `AHST_OFF_ENAB: rdata_d = {24'h000000, enab_q};
            `AHST_OFF_STAT: rdata_d = {28'h0000000, sw_pend_q, busy_q};
            default: rsel_ok = 1'b0;
        endcase
    end

    always @(posedge clk_sys) begin
        if (any_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~rsel_ok;
            if (setup & ~pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // rising edges of software trigger bits
    assign sw_rise = sw_q & ~sw_prev_q; // [RULE_09]

    // pending software requests; sw1 served before sw0, one at a time
    assign sv_idle = (sv_state_q == SV_IDLE);
    assign any_start = start_ch14 | start_ch15;
    assign sw_fire[1] = sw_pend_q[1] & ~conv_busy & sv_idle; // [RULE_10] [RULE_11]
    assign sw_fire[0] = sw_pend_q[0] & ~sw_pend_q[1] & ~conv_busy & sv_idle; // [RULE_11]

    ahst_cause_mux u_mux14 (
        .cause(cause_q[`AHST_CH14_MSB:`AHST_CH14_LSB]), // [RULE_01]
        .pwm_uf_or_match(pwm_uf_or_match),
        .pwm_match(pwm_match),
        .capture_unit_zero_evt(capture_unit_zero_evt),
        .capture_unit_one_evt(capture_unit_one_evt),
        .gtm_ovf(gtm_ovf),
        .capture_unit_fifteen_evt(capture_unit_fifteen_evt),
        .free_timer_sixteen_evt(free_timer_sixteen_evt),
        .free_timer_seventeen_evt(free_timer_seventeen_evt),
        .sw0_evt(sw_fire[`AHST_SW0_BIT]),
        .sw1_evt(sw_fire[`AHST_SW1_BIT]),
        .hit(hit14)
    );

    ahst_cause_mux u_mux15 (
        .cause(cause_q[`AHST_CH15_MSB:`AHST_CH15_LSB]), // [RULE_02]
        .pwm_uf_or_match(pwm_uf_or_match),
        .pwm_match(pwm_match),
        .capture_unit_zero_evt(capture_unit_zero_evt),
        .capture_unit_one_evt(capture_unit_one_evt),
        .gtm_ovf(gtm_ovf),
        .capture_unit_fifteen_evt(capture_unit_fifteen_evt),
        .free_timer_sixteen_evt(free_timer_sixteen_evt),
        .free_timer_seventeen_evt(free_timer_seventeen_evt),
        .sw0_evt(sw_fire[`AHST_SW0_BIT]),
        .sw1_evt(sw_fire[`AHST_SW1_BIT]),
        .hit(hit15)
    );

    // disabled channels ignore their events
    assign fire = {hit15 & enab_q[`AHST_EN_CH15],
                   hit14 & enab_q[`AHST_EN_CH14]}; // [RULE_15] [RULE_20]

    // a software request stays in flight until its conversion has ended,
    // so the second of two requests cannot merge into the first
    always @* begin
        sv_state_d = sv_state_q;
        case (sv_state_q)
            SV_IDLE: begin
                // a request that reaches no enabled channel is spent at once
                if ((|sw_fire) && (|fire)) begin
                    sv_state_d = SV_LAUNCH;
                end
            end
            SV_LAUNCH: begin
                if (any_start) begin
                    sv_state_d = SV_CONV;
                end
            end
            SV_CONV: begin
                if (!conv_busy) begin
                    sv_state_d = SV_IDLE;
                end
            end
            default: begin
                sv_state_d = SV_IDLE;
            end
        endcase
    end

    always @* begin
        // new edge wins over a served request
        sw_pend_d = (sw_pend_q & ~sw_fire) | sw_rise; // [RULE_10]
        // event caught, flag set on next strobe
        if (machine_cycle_strobe) begin
            ev_lat_d = 2'h0;
            flag_d = |(ev_lat_q | fire); // [RULE_19]
            busy_d = ev_lat_q | fire;
        end else begin
            ev_lat_d = ev_lat_q | fire;
            flag_d = 1'b0;
            busy_d = 2'h0;
        end
    end

    always @(posedge clk_sys) begin
        if (any_rst) begin
            sw_prev_q <= 2'h0;
            sw_pend_q <= 2'h0;
            ev_lat_q <= 2'h0;
            busy_q <= 2'h0;
            sv_state_q <= SV_IDLE;
            interrupt_request_flag <= 1'b0;
            start_ch14 <= 1'b0;
            start_ch15 <= 1'b0;
            chan_enable <= `AHST_RST_ENAB;
        end else begin
            sw_prev_q <= sw_q;
            sw_pend_q <= sw_pend_d;
            ev_lat_q <= ev_lat_d;
            busy_q <= busy_d;
            sv_state_q <= sv_state_d; // [RULE_11]
            interrupt_request_flag <= flag_d;
            // conversion starts one clock after the flag
            start_ch14 <= busy_q[0]; // [RULE_19]
            start_ch15 <= busy_q[1]; // [RULE_19]
            chan_enable <= enab_q;
        end
    end
endmodule

// [tb/ahst_trigger_assertions.sv]
`timescale 1ns/100ps
module ahst_trigger_chk (
    input wire clk_sys,
    input wire sys_rst,
    input wire watchdog_overflow,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire machine_cycle_strobe,
    input wire [7:0] chan_enable,
    input wire interrupt_request_flag,
    input wire start_ch14,
    input wire start_ch15
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    strobe_flag_a: assert property (interrupt_request_flag
        |-> $past(machine_cycle_strobe)) else $error("flag without strobe");
    en14_gate_a: assert property (start_ch14 |-> chan_enable[6])
        else $error("ch14 start while disabled");
    en15_gate_a: assert property (start_ch15 |-> chan_enable[7])
        else $error("ch15 start while disabled");
    src_reset_a: assert property (watchdog_overflow
        |=> chan_enable == 8'h00 && !start_ch14) else $error("reset source ignored");
    rst_clear_a: assert property ($fell(sys_rst) |-> chan_enable == 8'h00)
        else $error("enable not cleared");
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready");
    enable_copy_a: assert property (psel && penable && pready && pwrite
        && paddr == 12'h008 |-> ##2 chan_enable == $past(pwdata[7:0], 2))
        else $error("enable not stored");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
        else $error("no error on unmapped");
    start_flag_a: assert property ((start_ch14 || start_ch15)
        |-> $past(interrupt_request_flag)) else $error("start without flag");
endmodule
bind ahst_trigger ahst_trigger_chk i_chk (.*);

// [tb/ahst_evt_model.sv]
`timescale 1ns/100ps
module ahst_evt_model #(parameter STROBE_PER = 4, parameter BUSY_LEN = 6) (
    input wire clk_sys,
    input wire sys_rst,
    input wire fire,
    input wire [3:0] code,
    input wire start_any,
    output reg machine_cycle_strobe,
    output reg [3:0] pwm_uf_or_match,
    output reg [3:0] pwm_match,
    output reg [5:0] misc_evt,
    output reg conv_busy
);
    reg [3:0] div_q;
    reg [3:0] busy_q;
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            div_q <= 4'h0;
            busy_q <= 4'h0;
        end else begin
            div_q <= (div_q == STROBE_PER - 1) ? 4'h0 : div_q + 4'h1;
            busy_q <= start_any ? BUSY_LEN : (busy_q != 4'h0 ? busy_q - 4'h1 : 4'h0);
        end
    end
    always @* begin
        machine_cycle_strobe = (div_q == 4'h0) && !sys_rst;
        conv_busy = busy_q != 4'h0;
        // a match is also an underflow-or-match event
        pwm_uf_or_match = (fire && !code[3]) ? 4'h1 << code[1:0] : 4'h0;
        pwm_match = (fire && code[3:2] == 2'b01) ? 4'h1 << code[1:0] : 4'h0;
        misc_evt = (fire && code[3]) ? 6'h01 << (code - 4'h8) : 6'h00;
    end
endmodule

// [tb/ahst_trigger_bench.sv]
`timescale 1ns/100ps
module ahst_trigger_bench;
    reg clk_sys = 0, sys_rst = 1, ext_reset_pin_n = 1, break_instruction = 0;
    reg watchdog_overflow = 0, opcode_trap = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rng = 32'hF0D08B3E;
    reg [3:0] code = 0;
    reg [3:0] pstrb = 4'hF;
    wire [31:0] prdata;
    wire [7:0] chan_enable;
    wire [3:0] pwm_uf_or_match, pwm_match;
    wire pready, pslverr, machine_cycle_strobe, capture_unit_zero_evt, capture_unit_one_evt, gtm_ovf, capture_unit_fifteen_evt;
    wire free_timer_sixteen_evt, free_timer_seventeen_evt, conv_busy, interrupt_request_flag, start_ch14, start_ch15;
    integer n_errors = 0, samples_checked = 0, cyc = 0, i;
    reg [31:0] rd_q[$];
    reg [1:0] st_q[$];
    reg flag_seen = 0;
    ahst_trigger i_dut (.*);
    ahst_evt_model i_evt (.clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire), .code(code),
        .start_any(start_ch14 | start_ch15), .machine_cycle_strobe(machine_cycle_strobe),
        .pwm_uf_or_match(pwm_uf_or_match), .pwm_match(pwm_match), .conv_busy(conv_busy),
        .misc_evt({free_timer_seventeen_evt, free_timer_sixteen_evt, capture_unit_fifteen_evt, gtm_ovf, capture_unit_one_evt, capture_unit_zero_evt}));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task end_sim;
        begin
            if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge clk_sys);
            penable <= 1;
            do @(posedge clk_sys); while (!pready);
            {psel, penable} <= 2'b00;
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        begin
            rd_q.push_back(e);
            apb(0, a, 0);
        end
    endtask
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (start_ch14 | start_ch15) begin
            chk({start_ch15, start_ch14}, st_q.size() ? st_q.pop_front() : 2'b00);
            chk(flag_seen, 1);
        end
        flag_seen = interrupt_request_flag;
        if (psel & penable & pready & !pwrite) chk(prdata, rd_q.pop_front());
        if (psel & penable & pready) chk(pslverr, paddr == 12'h010);
        cyc = cyc + 1;
        if (cyc > 20000) begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 0;
        rd(0, 0);
        rd(4, 32'hFC);
        rd(8, 0);
        rd(12'h010, 0);
        pstrb <= 4'h1;
        apb(1, 0, 32'h1234);
        pstrb <= 4'hF;
        rd(0, 0);
        for (i = 0; i < 15; i = i + 1) begin
            rng = xs(rng);
            apb(1, 8, {24'h000000, ((i == 14) ? 2'b00 : 2'b11), rng[5:0]});
            apb(1, 0, {i[3:0], i[3:0] ^ 4'h8, 8'h00});
            if (i < 14) st_q.push_back(2'b10);
            @(posedge clk_sys);
            {code, fire} <= {i[3:0] == 4'hE ? 4'hD : i[3:0], 1'b1};
            @(posedge clk_sys);
            fire <= 0;
            repeat (20 + rng[9:6]) @(posedge clk_sys);
        end
        apb(1, 8, 32'hC0);
        apb(1, 0, 32'hFE00);
        st_q = {2'b10, 2'b01, 2'b01, 2'b10};
        apb(1, 4, 3);
        repeat (40) @(posedge clk_sys);
        rd(4, 32'hFF);
        apb(1, 4, 3);
        apb(1, 4, 0);
        apb(1, 4, 1);
        apb(1, 4, 3);
        repeat (40) @(posedge clk_sys);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1, 8, 32'h3F);
            rd(8, 32'h3F);
            {opcode_trap, watchdog_overflow, break_instruction} <= 3'b001 << i;
            ext_reset_pin_n <= i != 3;
            repeat (4) @(posedge clk_sys);
            {opcode_trap, watchdog_overflow, break_instruction, ext_reset_pin_n} <= 4'h1;
            repeat (4) @(posedge clk_sys);
            rd(8, 0);
        end
        repeat (20) @(posedge clk_sys);
        chk(st_q.size(), 0);
        end_sim;
    end
endmodule
